// ---- src/cidcfg_bank.sv ----
// Caller-identity gain and hysteresis configuration bank, indirect access.
// Assumes CPU register writes arrive as one-cycle strobes on clk_sys;
// analog detector outputs are asynchronous and are synchronised here.
//
// Overview of operation
// - Index register low three bits select target.
// - Bit 4 rising edge copies data register.
// - Indices zero to five map six registers.
// - Row nibble selects row frequency tolerance.
// - Column nibble selects column frequency tolerance.
// - Column bit 4 selects tone-detector mode.
// - Bit 5 makes frequency change reset present counter.
// - Bit 6 makes absent counter pause, not decrement.
// - Each gain nibble gives code zero to ten.
// - Individual enables gated by global; ring always.
// - Tone mode raises group presence bits three clocks after in-band energy, with no guard count, while the DTMF receiver is on.
`timescale 1ns/100ps
module cidcfg_bank (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // CPU register access
   input  wire logic        cfgDataWrEn,
   input  wire logic        cfgIndexWrEn,
   input  wire logic [7:0]  cpuWrData,
   output logic      [7:0]  cfgDataRd,
   output logic      [7:0]  cfgIndexRd,
   // Enable bits from the CPU
   input  wire logic        globalEnable,
   input  wire logic        fskEnableBit,
   input  wire logic        alertEnableBit,
   input  wire logic        dtmfEnableBit,
   output logic             fskDecoderOn,
   output logic             alertDetectorOn,
   output logic             dtmfReceiverOn,
   output logic             ringDetectorOn,
   // Analog detector levels
   input  wire logic        toneHighEnergy,
   input  wire logic        toneLowEnergy,
   input  wire logic        dtmfToneSeen,
   input  wire logic        dtmfFreqChanged,
   // Guard time limits
   input  wire logic [7:0]  presentLimit,
   input  wire logic [7:0]  absentLimit,
   // DTMF configuration
   output logic      [1:0]  rowTolCode,
   output logic      [1:0]  colTolCode,
   output logic             toneDetectMode,
   // Gain codes
   output logic      [3:0]  gainAlert,
   output logic      [3:0]  gainFsk,
   output logic      [3:0]  gainDtmfHigh,
   output logic      [3:0]  gainDtmfLow,
   // Hysteresis in millivolts
   output logic      [5:0]  alertHystMv,
   output logic      [5:0]  dtmfHystMv,
   output logic      [5:0]  fskInHystMv,
   output logic      [5:0]  fskDetHystMv,
   // Detector status
   output logic             toneHighPresent,
   output logic             toneLowPresent,
   output logic             dtmfValid,
   output logic      [7:0]  presentCount,
   output logic      [7:0]  absentCount
);

   logic [7:0] cfgReg_q [cidcfg_pkg::NUM_CFG];
   logic       strobePrev_q;
   logic       strobeRise;
   logic [2:0] cfgIdx;
   logic [3:0] detSync;

   // Tolerance decode for row and column nibbles
   function automatic logic [1:0] tolDecode(input logic [3:0] nib);
      logic [1:0] code;
      code = cidcfg_pkg::TOL_RESERVED;
      if (nib == 4'h0)
         code = cidcfg_pkg::TOL_NARROW;
      else if (nib == 4'h1)
         code = cidcfg_pkg::TOL_MEDIUM;
      else if (nib[3:1] == 3'h1)
         code = cidcfg_pkg::TOL_WIDE;
      return code;
   endfunction

   // Gain code, values above ten clamp
   function automatic logic [3:0] gainClamp(input logic [3:0] nib);
      return (nib > cidcfg_pkg::GAIN_MAX) ? cidcfg_pkg::GAIN_MAX : nib;
   endfunction

   function automatic logic [5:0] hystMv(input logic [5:0] base, input logic [3:0] nib);
      return 6'(base + cidcfg_pkg::HYST_STEP_MV * {2'h0, nib});
   endfunction

   // CPU-visible data and index registers
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         cfgDataRd <= cidcfg_pkg::RST_DATA;
      else if (cfgDataWrEn)
         cfgDataRd <= cpuWrData;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         cfgIndexRd <= cidcfg_pkg::RST_INDEX;
      else if (cfgIndexWrEn)
         cfgIndexRd <= cpuWrData;
   end

   // Strobe edge detect on index bit 4
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         strobePrev_q <= 1'b0;
      else
         strobePrev_q <= cfgIndexRd[cidcfg_pkg::STROBE_BIT];
   end

   assign strobeRise = cfgIndexRd[cidcfg_pkg::STROBE_BIT] & ~strobePrev_q;
   assign cfgIdx     = cfgIndexRd[cidcfg_pkg::IDX_W-1:0];

   // Internal registers; indices six and seven are ignored
   for (genvar i = 0; i < cidcfg_pkg::NUM_CFG; i++)
   begin : g_cfg
      localparam logic [7:0] RST_VAL = (i == 0) ? cidcfg_pkg::RST_ROW_TOL :
                                       (i == 1) ? cidcfg_pkg::RST_COL_MODE :
                                       (i <= 3) ? cidcfg_pkg::RST_GAIN : cidcfg_pkg::RST_HYST;
      always_ff @(posedge clk_sys or negedge resetn)
      begin
         if (!resetn)
            cfgReg_q[i] <= RST_VAL;
         else if (strobeRise && cfgIdx == 3'(i))
            cfgReg_q[i] <= cfgDataRd;
      end
   end

   // Tolerance and mode fields; reserved row bits are not used
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rowTolCode     <= cidcfg_pkg::TOL_NARROW;
         colTolCode     <= cidcfg_pkg::TOL_NARROW;
         toneDetectMode <= 1'b0;
      end
      else
      begin
         rowTolCode     <= tolDecode(cfgReg_q[cidcfg_pkg::IDX_ROW_TOL][3:0]);
         colTolCode     <= tolDecode(cfgReg_q[cidcfg_pkg::IDX_COL_MODE][3:0]);
         toneDetectMode <= cfgReg_q[cidcfg_pkg::IDX_COL_MODE][cidcfg_pkg::MODE_TONE_BIT];
      end
   end

   // Gain nibbles
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         gainAlert    <= cidcfg_pkg::RST_GAIN[7:4];
         gainFsk      <= cidcfg_pkg::RST_GAIN[3:0];
         gainDtmfHigh <= cidcfg_pkg::RST_GAIN[7:4];
         gainDtmfLow  <= cidcfg_pkg::RST_GAIN[3:0];
      end
      else
      begin
         gainAlert    <= gainClamp(cfgReg_q[cidcfg_pkg::IDX_GAIN_AF][7:4]);
         gainFsk      <= gainClamp(cfgReg_q[cidcfg_pkg::IDX_GAIN_AF][3:0]);
         gainDtmfHigh <= gainClamp(cfgReg_q[cidcfg_pkg::IDX_GAIN_DTMF][7:4]);
         gainDtmfLow  <= gainClamp(cfgReg_q[cidcfg_pkg::IDX_GAIN_DTMF][3:0]);
      end
   end

   // Hysteresis levels
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         alertHystMv  <= cidcfg_pkg::HYST_BASE13_MV;
         dtmfHystMv   <= cidcfg_pkg::HYST_BASE6_MV;
         fskInHystMv  <= cidcfg_pkg::HYST_BASE13_MV;
         fskDetHystMv <= cidcfg_pkg::HYST_BASE13_MV;
      end
      else
      begin
         alertHystMv  <= hystMv(cidcfg_pkg::HYST_BASE13_MV, cfgReg_q[cidcfg_pkg::IDX_HYST_AD][7:4]);
         dtmfHystMv   <= hystMv(cidcfg_pkg::HYST_BASE6_MV, cfgReg_q[cidcfg_pkg::IDX_HYST_AD][3:0]);
         fskInHystMv  <= hystMv(cidcfg_pkg::HYST_BASE13_MV, cfgReg_q[cidcfg_pkg::IDX_HYST_FL][7:4]);
         fskDetHystMv <= hystMv(cidcfg_pkg::HYST_BASE13_MV, cfgReg_q[cidcfg_pkg::IDX_HYST_FL][3:0]);
      end
   end

   // Detector enables under the global enable; ring detector always on
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         fskDecoderOn    <= 1'b0;
         alertDetectorOn <= 1'b0;
         dtmfReceiverOn  <= 1'b0;
         ringDetectorOn  <= 1'b0;
      end
      else
      begin
         fskDecoderOn    <= globalEnable & fskEnableBit;
         alertDetectorOn <= globalEnable & alertEnableBit;
         dtmfReceiverOn  <= globalEnable & dtmfEnableBit;
         ringDetectorOn  <= 1'b1;
      end
   end

   cidcfg_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .asyncIn ({dtmfFreqChanged, dtmfToneSeen, toneLowEnergy, toneHighEnergy}),
      .syncOut (detSync)
   );

   // Tone presence bits follow in-band energy in tone mode
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         toneHighPresent <= 1'b0;
         toneLowPresent  <= 1'b0;
      end
      else
      begin
         toneHighPresent <= detSync[0] & toneDetectMode & dtmfReceiverOn;
         toneLowPresent  <= detSync[1] & toneDetectMode & dtmfReceiverOn;
      end
   end

   cidcfg_guard u_guard (
      .clk_sys       (clk_sys),
      .resetn        (resetn),
      .runEn         (dtmfReceiverOn & ~toneDetectMode),
      .resetOnChange (cfgReg_q[cidcfg_pkg::IDX_COL_MODE][cidcfg_pkg::PT_RST_BIT]),
      .pauseOnReturn (cfgReg_q[cidcfg_pkg::IDX_COL_MODE][cidcfg_pkg::AT_PAUSE_BIT]),
      .presentLimit  (presentLimit),
      .absentLimit   (absentLimit),
      .toneSeen      (detSync[2]),
      .freqChanged   (detSync[3]),
      .presentCount  (presentCount),
      .absentCount   (absentCount),
      .toneValid     (dtmfValid)
   );

   sequence s_strobe_armed;
      cfgIndexWrEn && cpuWrData[cidcfg_pkg::STROBE_BIT] && !cfgIndexRd[cidcfg_pkg::STROBE_BIT]
         && cpuWrData[2:0] <= cidcfg_pkg::IDX_LAST;
   endsequence

   sequence s_latched(logic [2:0] idx, logic [7:0] val);
      ##2 cfgReg_q[idx] == val;
   endsequence

   a_strobe_latch : assert property (@(posedge clk_sys) disable iff (!resetn)
      s_strobe_armed ##0 !cfgDataWrEn |-> s_latched($past(cpuWrData[2:0], 2), $past(cfgDataRd)))
      else $error("strobe did not latch data into selected register");
   a_hold_value : assert property (@(posedge clk_sys) disable iff (!resetn)
      !(strobeRise && cfgIdx == cidcfg_pkg::IDX_ROW_TOL) |=> $stable(cfgReg_q[0]))
      else $error("row register changed without strobe");
   a_row_tol_map : assert property (@(posedge clk_sys) disable iff (!resetn)
      cfgReg_q[0][3:0] == 4'h3 |=> rowTolCode == cidcfg_pkg::TOL_WIDE)
      else $error("row tolerance decode wrong");
   a_col_tol_map : assert property (@(posedge clk_sys) disable iff (!resetn)
      cfgReg_q[1][3:0] == 4'h1 |=> colTolCode == cidcfg_pkg::TOL_MEDIUM)
      else $error("column tolerance decode wrong");
   a_mode_select : assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 toneDetectMode == $past(cfgReg_q[1][4]))
      else $error("tone mode does not follow column bit 4");
   a_gain_range : assert property (@(posedge clk_sys) disable iff (!resetn)
      gainAlert <= cidcfg_pkg::GAIN_MAX && gainDtmfLow <= cidcfg_pkg::GAIN_MAX)
      else $error("gain code above ten");
   a_alert_hyst : assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 alertHystMv == cidcfg_pkg::HYST_BASE13_MV + cidcfg_pkg::HYST_STEP_MV * {2'h0, $past(cfgReg_q[4][7:4])})
      else $error("alert hysteresis wrong");
   a_dtmf_hyst : assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 dtmfHystMv == cidcfg_pkg::HYST_BASE6_MV + cidcfg_pkg::HYST_STEP_MV * {2'h0, $past(cfgReg_q[4][3:0])})
      else $error("dtmf hysteresis wrong");
   a_fsk_hyst : assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 fskDetHystMv == cidcfg_pkg::HYST_BASE13_MV + cidcfg_pkg::HYST_STEP_MV * {2'h0, $past(cfgReg_q[5][3:0])})
      else $error("fsk detector hysteresis wrong");
   a_enable_gate : assert property (@(posedge clk_sys) disable iff (!resetn)
      !globalEnable |=> !fskDecoderOn && !alertDetectorOn && !dtmfReceiverOn && ringDetectorOn)
      else $error("detector enabled without global enable");
   a_tone_presence : assert property (@(posedge clk_sys) disable iff (!resetn)
      toneDetectMode && dtmfReceiverOn && $rose(detSync[0]) |=> toneHighPresent)
      else $error("high group presence not raised");

endmodule

// ---- src/cidcfg_guard.sv ----
// DTMF present-time and absent-time guard counters.
// Assumes synchronised detector inputs and one count per clock.
`timescale 1ns/100ps
module cidcfg_guard (
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           resetn,
   // Control
   input  wire logic                           runEn,
   input  wire logic                           resetOnChange,
   input  wire logic                           pauseOnReturn,
   input  wire logic [cidcfg_pkg::CNT_W-1:0]   presentLimit,
   input  wire logic [cidcfg_pkg::CNT_W-1:0]   absentLimit,
   // Detector
   input  wire logic                           toneSeen,
   input  wire logic                           freqChanged,
   // Status
   output logic      [cidcfg_pkg::CNT_W-1:0]   presentCount,
   output logic      [cidcfg_pkg::CNT_W-1:0]   absentCount,
   output logic                                toneValid
);

   // Present-time up-counter
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         presentCount <= '0;
      else if (!runEn || !toneSeen || toneValid)
         presentCount <= '0;
      else if (resetOnChange && freqChanged)
         presentCount <= '0;
      else if (presentCount != presentLimit)
         presentCount <= presentCount + 1'b1;
   end

   // Absent-time counter
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         absentCount <= '0;
      else if (!runEn || !toneValid)
         absentCount <= '0;
      else if (!toneSeen)
      begin
         if (absentCount != absentLimit)
            absentCount <= absentCount + 1'b1;
      end
      else if (!pauseOnReturn && absentCount != '0)
         absentCount <= absentCount - 1'b1;
   end

   // Valid flag
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         toneValid <= 1'b0;
      else if (!runEn)
         toneValid <= 1'b0;
      else if (!toneValid && toneSeen && presentCount == presentLimit)
         toneValid <= 1'b1;
      else if (toneValid && !toneSeen && absentCount == absentLimit)
         toneValid <= 1'b0;
   end

   a_pt_change_reset : assert property (@(posedge clk_sys) disable iff (!resetn)
      runEn && toneSeen && !toneValid && resetOnChange && freqChanged |=> presentCount == '0)
      else $error("present counter not cleared on frequency change");
   a_pt_ignore_change : assert property (@(posedge clk_sys) disable iff (!resetn)
      runEn && toneSeen && !toneValid && !resetOnChange && presentCount < presentLimit
      |=> presentCount == $past(presentCount) + 1'b1)
      else $error("present counter did not advance");
   a_at_pause_hold : assert property (@(posedge clk_sys) disable iff (!resetn)
      runEn && toneValid && toneSeen && pauseOnReturn |=> $stable(absentCount))
      else $error("absent counter moved while paused");
   a_at_count_down : assert property (@(posedge clk_sys) disable iff (!resetn)
      runEn && toneValid && toneSeen && !pauseOnReturn && absentCount != '0
      |=> absentCount == $past(absentCount) - 1'b1)
      else $error("absent counter did not count down");

endmodule

// ---- src/cidcfg_pkg.sv ----
// Constants for the caller-identity gain and hysteresis configuration bank.
// Assumes a single CPU clock domain; no bus beyond the two CPU registers.
package cidcfg_pkg;

   localparam int unsigned REG_W       = 8;
   localparam int unsigned NUM_CFG     = 6;
   localparam int unsigned IDX_W       = 3;
   localparam int unsigned NIB_W       = 4;
   localparam int unsigned HYST_W      = 6;
   localparam int unsigned CNT_W       = 8;

   // Internal register indices
   localparam logic [2:0] IDX_ROW_TOL    = 3'h0;
   localparam logic [2:0] IDX_COL_MODE   = 3'h1;
   localparam logic [2:0] IDX_GAIN_AF    = 3'h2;
   localparam logic [2:0] IDX_GAIN_DTMF  = 3'h3;
   localparam logic [2:0] IDX_HYST_AD    = 3'h4;
   localparam logic [2:0] IDX_HYST_FL    = 3'h5;
   localparam logic [2:0] IDX_LAST       = 3'h5;

   // Field positions
   localparam int unsigned STROBE_BIT    = 4;
   localparam int unsigned MODE_TONE_BIT = 4;
   localparam int unsigned PT_RST_BIT    = 5;
   localparam int unsigned AT_PAUSE_BIT  = 6;
   localparam int unsigned HI_NIB_LSB    = 4;
   localparam int unsigned LO_NIB_LSB    = 0;

   // Reset values
   localparam logic [7:0] RST_DATA       = 8'h00;
   localparam logic [7:0] RST_INDEX      = 8'h00;
   localparam logic [7:0] RST_ROW_TOL    = 8'h00;
   localparam logic [7:0] RST_COL_MODE   = 8'h00;
   localparam logic [7:0] RST_GAIN       = 8'h55;
   localparam logic [7:0] RST_HYST       = 8'h00;

   // Tolerance codes
   localparam logic [1:0] TOL_NARROW     = 2'h0;
   localparam logic [1:0] TOL_MEDIUM     = 2'h1;
   localparam logic [1:0] TOL_WIDE       = 2'h2;
   localparam logic [1:0] TOL_RESERVED   = 2'h3;

   // Gain and hysteresis scaling
   localparam logic [3:0] GAIN_MAX       = 4'hA;
   localparam logic [5:0] HYST_BASE13_MV = 6'h0D;
   localparam logic [5:0] HYST_BASE6_MV  = 6'h06;
   localparam logic [5:0] HYST_STEP_MV   = 6'h03;

endpackage

// ---- src/cidcfg_sync.sv ----
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous levels from the analog front end.
`timescale 1ns/100ps
module cidcfg_sync #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   // Data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;

   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn)
      begin
         if (!resetn)
         begin
            meta_q[i]  <= 1'b0;
            syncOut[i] <= 1'b0;
         end
         else
         begin
            meta_q[i]  <= asyncIn[i];
            syncOut[i] <= meta_q[i];
         end
      end
   end

endmodule

// ---- verification/cidcfg_bank_tb.sv ----
// Self-checking bench for the caller-identity configuration bank.
// Assumes the bank alone, driven at its ports on the 10 MHz system clock.
`timescale 1ns/100ps
module cidcfg_bank_tb;
   logic       clk_sys, resetn, cfgDataWrEn, cfgIndexWrEn;
   logic [7:0] cpuWrData, cfgDataRd, cfgIndexRd, presentLimit, absentLimit, presentCount, absentCount;
   logic       globalEnable, fskEnableBit, alertEnableBit, dtmfEnableBit;
   logic       fskDecoderOn, alertDetectorOn, dtmfReceiverOn, ringDetectorOn;
   logic       toneHighEnergy, toneLowEnergy, dtmfToneSeen, dtmfFreqChanged;
   logic [1:0] rowTolCode, colTolCode;
   logic       toneDetectMode, toneHighPresent, toneLowPresent, dtmfValid;
   logic [3:0] gainAlert, gainFsk, gainDtmfHigh, gainDtmfLow;
   logic [5:0] alertHystMv, dtmfHystMv, fskInHystMv, fskDetHystMv;
   int         err_count, cmp_count, cycles;

   cidcfg_bank i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .cfgDataWrEn(cfgDataWrEn), .cfgIndexWrEn(cfgIndexWrEn),
      .cpuWrData(cpuWrData), .cfgDataRd(cfgDataRd), .cfgIndexRd(cfgIndexRd),
      .globalEnable(globalEnable), .fskEnableBit(fskEnableBit), .alertEnableBit(alertEnableBit),
      .dtmfEnableBit(dtmfEnableBit), .fskDecoderOn(fskDecoderOn), .alertDetectorOn(alertDetectorOn),
      .dtmfReceiverOn(dtmfReceiverOn), .ringDetectorOn(ringDetectorOn), .toneHighEnergy(toneHighEnergy),
      .toneLowEnergy(toneLowEnergy), .dtmfToneSeen(dtmfToneSeen), .dtmfFreqChanged(dtmfFreqChanged),
      .presentLimit(presentLimit), .absentLimit(absentLimit), .rowTolCode(rowTolCode),
      .colTolCode(colTolCode), .toneDetectMode(toneDetectMode), .gainAlert(gainAlert), .gainFsk(gainFsk),
      .gainDtmfHigh(gainDtmfHigh), .gainDtmfLow(gainDtmfLow), .alertHystMv(alertHystMv),
      .dtmfHystMv(dtmfHystMv), .fskInHystMv(fskInHystMv), .fskDetHystMv(fskDetHystMv),
      .toneHighPresent(toneHighPresent), .toneLowPresent(toneLowPresent), .dtmfValid(dtmfValid),
      .presentCount(presentCount), .absentCount(absentCount)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic complete_run;
      $display("Counts: %0d compared, %0d unexpected", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         err_count++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   // One CPU write; sel high targets the index register
   task automatic wr(input logic sel, input logic [7:0] v);
      @(posedge clk_sys);
      cfgDataWrEn  <= !sel;
      cfgIndexWrEn <= sel;
      cpuWrData    <= v;
      @(posedge clk_sys);
      cfgDataWrEn  <= 1'b0;
      cfgIndexWrEn <= 1'b0;
   endtask

   // Data, index with strobe low, then strobe high
   task automatic cfg(input logic [2:0] idx, input logic [7:0] v);
      wr(1'b0, v);
      wr(1'b1, {5'h00, idx});
      wr(1'b1, {5'h02, idx});
      hold(4);
   endtask

   task automatic test_reset;
      chk("dataRd", 8'h00, cfgDataRd);
      chk("indexRd", 8'h00, cfgIndexRd);
      chk("tolCodes", 8'h00, 8'({rowTolCode, colTolCode, toneDetectMode}));
      chk("gainAf", 8'h55, {gainAlert, gainFsk});
      chk("gainDtmf", 8'h55, {gainDtmfHigh, gainDtmfLow});
      chk("hystAlert", 8'h0D, 8'(alertHystMv));
      chk("hystDtmf", 8'h06, 8'(dtmfHystMv));
      chk("hystFsk", 8'h0D, 8'(fskInHystMv));
      chk("hystFskDet", 8'h0D, 8'(fskDetHystMv));
      chk("enables", 8'h01, 8'({fskDecoderOn, alertDetectorOn, dtmfReceiverOn, ringDetectorOn}));
      $display("test reset done");
   endtask

   task automatic test_suggested;
      cfg(3'h0, 8'h01);
      cfg(3'h1, 8'h61);
      cfg(3'h2, 8'h99);
      cfg(3'h3, 8'hA7);
      cfg(3'h4, 8'h35);
      cfg(3'h5, 8'h33);
      chk("rowTol", 8'h01, 8'(rowTolCode));
      chk("colTol", 8'h01, 8'(colTolCode));
      chk("mode", 8'h00, 8'(toneDetectMode));
      chk("gainAf", 8'h99, {gainAlert, gainFsk});
      chk("gainDtmf", 8'hA7, {gainDtmfHigh, gainDtmfLow});
      chk("hystAlert", 8'h16, 8'(alertHystMv));
      chk("hystDtmf", 8'h15, 8'(dtmfHystMv));
      chk("hystFsk", 8'h16, 8'(fskInHystMv));
      chk("hystFskDet", 8'h16, 8'(fskDetHystMv));
      chk("dataRd", 8'h33, cfgDataRd);
      chk("indexRd", 8'h15, cfgIndexRd);
      $display("test suggested done");
   endtask

   task automatic test_tol;
      logic [7:0] nib [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08};
      logic [7:0] code [6] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03};
      for (int i = 0; i < 6; i++)
      begin
         cfg(3'h0, nib[i]);
         chk("rowTol", code[i], 8'(rowTolCode));
         cfg(3'h1, nib[i]);
         chk("colTol", code[i], 8'(colTolCode));
      end
      $display("test tolerance done");
   endtask

   task automatic test_refuse;
      wr(1'b0, 8'h77);
      wr(1'b1, 8'h06);
      wr(1'b1, 8'h16);
      wr(1'b1, 8'h07);
      wr(1'b1, 8'h17);
      hold(4);
      chk("hystFsk", 8'h16, 8'(fskInHystMv));
      chk("hystAlert", 8'h16, 8'(alertHystMv));
      wr(1'b1, 8'h0D);
      wr(1'b1, 8'h1D);
      hold(4);
      chk("hystFsk", 8'h22, 8'(fskInHystMv));
      chk("hystFskDet", 8'h22, 8'(fskDetHystMv));
      wr(1'b0, 8'h44);
      wr(1'b1, 8'h1D);
      hold(4);
      chk("hystFskDet", 8'h22, 8'(fskDetHystMv));
      cfg(3'h2, 8'hBF);
      chk("gainClamp", 8'hAA, {gainAlert, gainFsk});
      $display("test refuse done");
   endtask

   task automatic test_enable;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk_sys);
         {globalEnable, fskEnableBit, alertEnableBit, dtmfEnableBit} <= 4'(i);
         hold(2);
         chk("enables", 8'({(i[3] ? i[2:0] : 3'h0), 1'b1}),
             8'({fskDecoderOn, alertDetectorOn, dtmfReceiverOn, ringDetectorOn}));
      end
      $display("test enable done");
   endtask

   task automatic test_tone;
      cfg(3'h1, 8'h10);
      chk("mode", 8'h01, 8'(toneDetectMode));
      @(posedge clk_sys);
      toneHighEnergy <= 1'b1;
      hold(4);
      chk("presence", 8'h02, 8'({toneHighPresent, toneLowPresent}));
      @(posedge clk_sys);
      toneHighEnergy <= 1'b0;
      toneLowEnergy  <= 1'b1;
      hold(4);
      chk("presence", 8'h01, 8'({toneHighPresent, toneLowPresent}));
      cfg(3'h1, 8'h00);
      chk("presence", 8'h00, 8'({toneHighPresent, toneLowPresent}));
      @(posedge clk_sys);
      toneLowEnergy <= 1'b0;
      $display("test tone done");
   endtask

   // Absent counter over one tone gap; expects a drop of dn over two cycles
   task automatic gap(input logic [7:0] dn);
      logic [7:0] a;
      @(posedge clk_sys);
      dtmfToneSeen <= 1'b0;
      repeat (20) @(posedge clk_sys);
      dtmfToneSeen <= 1'b1;
      hold(4);
      a = absentCount;
      hold(2);
      chk("absentCount", a - dn, absentCount);
   endtask

   task automatic test_guard;
      @(posedge clk_sys);
      dtmfToneSeen    <= 1'b1;
      dtmfFreqChanged <= 1'b1;
      hold(20);
      chk("valid", 8'h01, 8'(dtmfValid));
      gap(8'h02);
      cfg(3'h1, 8'h40);
      gap(8'h00);
      cfg(3'h1, 8'h20);
      @(posedge clk_sys);
      dtmfToneSeen <= 1'b0;
      hold(60);
      chk("valid", 8'h00, 8'(dtmfValid));
      @(posedge clk_sys);
      dtmfToneSeen <= 1'b1;
      hold(30);
      chk("valid", 8'h00, 8'(dtmfValid));
      chk("presentCount", 8'h00, presentCount);
      @(posedge clk_sys);
      dtmfFreqChanged <= 1'b0;
      hold(20);
      chk("valid", 8'h01, 8'(dtmfValid));
      $display("test guard done");
   endtask

   initial
   begin
      {resetn, cfgDataWrEn, cfgIndexWrEn, cpuWrData} = 11'h000;
      {globalEnable, fskEnableBit, alertEnableBit, dtmfEnableBit} = 4'h0;
      {toneHighEnergy, toneLowEnergy, dtmfToneSeen, dtmfFreqChanged} = 4'h0;
      presentLimit = 8'h05;
      absentLimit  = 8'h28;
      err_count = 0;
      cmp_count = 0;
      cycles    = 0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      hold(1);
      test_reset();
      test_suggested();
      test_tol();
      test_refuse();
      test_enable();
      test_tone();
      test_guard();
      complete_run();
   end
endmodule
